// ===== rtl/segment_type_access_checker.sv
// Notes on behaviour
// R1 - non-writable data into stack register faults
// R2 - expand-down stack grows at bottom
// R3 - set accessed bit on every load from writable descriptor memory; a load while a write-back is still busy gets none
// R4 - accessed bit only cleared by software
// R5 - code type bits: accessed, read, conforming
// R6 - execute-only unless read bit set
// R7 - never write through code segment
// R8 - conforming transfer keeps current privilege
// R9 - nonconforming other-privilege direct transfer faults
// R10 - transfer to less privileged code faults
// R11 - data refused to less privileged code; stack and code register loads take no privilege check
// R12 - software presets accessed bit in rom
// R13 - descriptor flag clear means system descriptor
// R14 - system segments locate tables, gates pointers
// R15 - legacy system segment type decode
// R16 - legacy gate type decode, reserved codes
// R17 - long mode system types, upper half
// R18 - long mode system descriptors are wide
// R19 - top type bit selects code/data
// R20 - two-bit privilege compared in load and transfer checks
// R21 - data type bits: accessed, write, expand-down
// R22 - reserved system types flagged invalid
// R23 - fault same cycle, blocks completion
`timescale 1ns/1ps
`default_nettype none
module segment_type_access_checker (
	input wire logic sys_clk_i, // core clock, 10 MHz
	input wire logic srst_i, // synchronous reset, active high
	input wire logic long_mode_i, // 64-bit long mode active
	input wire logic [1:0] cur_priv_i, // current privilege level
	input wire logic load_req_i, // selector load request
	input wire seg_check_pkg::seg_target_t load_target_i, // target register
	input wire logic xfer_req_i, // call or jump request, direct or through a gate
	input wire logic xfer_via_gate_i, // transfer goes through a gate
	input wire logic [3:0] desc_type_i, // descriptor type field
	input wire logic desc_s_i, // descriptor-type flag
	input wire logic [1:0] desc_priv_i, // descriptor privilege
	input wire logic desc_mem_wr_ok_i, // descriptor memory is writable
	input wire logic data_acc_req_i, // memory access through a segment
	input wire logic data_acc_wr_i, // that access is a write
	input wire logic [3:0] acc_type_i, // type of the accessed segment
	input wire logic acc_s_i, // s flag of the accessed segment
	input wire logic acc_wr_done_i, // accessed-bit write completed
	output logic general_protection_fault_o, // fault, same cycle
	output logic load_ok_o, // load may complete
	output logic xfer_ok_o, // transfer may complete
	output logic acc_ok_o, // memory access allowed
	output logic [1:0] next_priv_o, // privilege after transfer
	output logic acc_set_req_o, // write accessed bit to descriptor
	output logic [3:0] acc_set_type_o, // type value to write
	output logic stack_grows_down_o, // loaded stack is expand-down
	output seg_check_pkg::sys_class_t sys_class_o, // registered class
	output logic sys_invalid_o, // registered reserved-type flag
	output logic [4:0] desc_bytes_o // registered descriptor size
);
	import seg_check_pkg::*;

	type_dec_if dl ();
	type_dec_if da ();
	logic [3:0] acc_type_set;
	logic load_fault;
	logic xfer_fault;
	logic acc_fault;
	logic priv_fault;
	logic [1:0] eff_priv;
	wb_state_t wb_state;
	wb_state_t next_wb_state;
	logic [3:0] wb_type;
	logic [3:0] next_wb_type;
	logic stack_down;
	logic next_stack_down;
	sys_class_t sys_class_q;
	sys_class_t next_sys_class;
	logic sys_inv_q;
	logic next_sys_inv;
	logic [4:0] desc_bytes_q;
	logic [4:0] next_desc_bytes;
	logic [1:0] priv_q;
	logic [1:0] next_priv;

	// one decoder for the descriptor being loaded, one for the access
	seg_type_decoder u_dec_load (
		.dec(dl.decoder)
	);
	seg_type_decoder u_dec_acc (
		.dec(da.decoder)
	);

	assign dl.type_code = desc_type_i;
	assign dl.s_flag = desc_s_i;
	assign dl.long_mode = long_mode_i;
	assign da.type_code = acc_type_i;
	assign da.s_flag = acc_s_i;
	assign da.long_mode = long_mode_i;

	// privilege check shared by loads and transfers: lower number is more privileged
	function automatic logic less_priv_than(input logic [1:0] a,
		input logic [1:0] b);
		return a > b;
	endfunction

	// segment load checks
	always_comb begin
		load_fault = 1'b0;
		priv_fault = 1'b0;
		if (load_req_i) begin
			if (load_target_i == SEG_STACK) begin
				// stack needs a writable data segment
				if (!dl.wr_ok) begin
					load_fault = 1'b1; // R1
				end
			end else if (load_target_i != SEG_CODE) begin
				// data registers take data or readable code
				if (!dl.rd_ok) begin
					load_fault = 1'b1; // R6
				end
				// data is nonconforming; readable conforming code is exempt
				priv_fault = !dl.conforming &&
					less_priv_than(cur_priv_i, desc_priv_i); // R11 R20
			end
			if (dl.is_system) begin
				load_fault = 1'b1; // R22
			end
		end
	end

	// control transfer checks and resulting privilege
	always_comb begin
		xfer_fault = 1'b0;
		eff_priv = cur_priv_i;
		if (xfer_req_i && !xfer_via_gate_i) begin
			if (!dl.is_code) begin
				xfer_fault = 1'b1;
			end else if (less_priv_than(desc_priv_i, cur_priv_i)) begin
				xfer_fault = 1'b1; // R10 R20
			end else if (!dl.conforming && desc_priv_i != cur_priv_i) begin
				xfer_fault = 1'b1; // R9
			end else begin
				eff_priv = cur_priv_i; // R8
			end
		end else if (xfer_req_i && xfer_via_gate_i) begin
			// gate path: the gate itself must be a valid gate type
			// the upper half of a wide descriptor holds no entry point
			xfer_fault = dl.sys_invalid || dl.sys_class == SYS_CLS_LDT ||
				dl.sys_class == SYS_CLS_TSS ||
				dl.sys_class == SYS_CLS_UPPER || !dl.is_system; // R14 R22
		end
	end

	// access through an already loaded segment
	always_comb begin
		acc_fault = 1'b0;
		if (data_acc_req_i) begin
			if (data_acc_wr_i && !da.wr_ok) begin
				acc_fault = 1'b1; // R7
			end else if (!data_acc_wr_i && !da.rd_ok) begin
				acc_fault = 1'b1; // R6
			end
		end
	end

	// faults block completion in the request's own cycle
	assign general_protection_fault_o = load_fault || priv_fault ||
		xfer_fault || acc_fault; // R23
	assign load_ok_o = load_req_i && !load_fault && !priv_fault; // R23
	assign xfer_ok_o = xfer_req_i && !xfer_fault; // R23
	assign acc_ok_o = data_acc_req_i && !acc_fault; // R23

	// accessed bit is only ever or-ed in; clearing is left to software
	assign acc_type_set = desc_type_i |
		(4'h1 << TYPE_ACC_BIT); // R3 R4

	// accessed-bit write-back, skipped for read-only descriptor memory
	always_comb begin
		next_wb_state = wb_state;
		next_wb_type = wb_type;
		case (wb_state)
			WB_IDLE: begin
				if (load_ok_o && desc_s_i && desc_mem_wr_ok_i &&
					!dl.acc) begin
					next_wb_state = WB_WRITE; // R3
					next_wb_type = acc_type_set;
				end
			end
			WB_WRITE: begin
				if (acc_wr_done_i) begin
					next_wb_state = WB_DONE;
				end
			end
			WB_DONE: begin
				next_wb_state = WB_IDLE;
			end
			default: begin
				next_wb_state = WB_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			wb_state <= WB_IDLE;
			wb_type <= 4'h0;
		end else begin
			wb_state <= next_wb_state;
			wb_type <= next_wb_type;
		end
	end

	assign acc_set_req_o = (wb_state == WB_WRITE);
	assign acc_set_type_o = wb_type;

	// loaded-descriptor status, kept for the core's limit logic
	always_comb begin
		next_stack_down = stack_down;
		next_sys_class = sys_class_q;
		next_sys_inv = sys_inv_q;
		next_desc_bytes = desc_bytes_q;
		next_priv = priv_q;
		if (load_ok_o && load_target_i == SEG_STACK) begin
			// expand-down: limit changes move the bottom, not the top
			next_stack_down = dl.expand_down; // R2
		end
		if (load_req_i || xfer_req_i) begin
			next_sys_class = dl.sys_class; // R13 R15 R16 R17
			next_sys_inv = dl.sys_invalid; // R22
			next_desc_bytes = dl.desc_bytes; // R18
		end
		if (xfer_ok_o && !xfer_via_gate_i) begin
			next_priv = eff_priv; // R8
		end else if (!xfer_req_i) begin
			next_priv = cur_priv_i;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			stack_down <= 1'b0;
			sys_class_q <= SYS_NONE;
			sys_inv_q <= 1'b0;
			desc_bytes_q <= DESC_BYTES_LEGACY;
			priv_q <= PRIV_MOST;
		end else begin
			stack_down <= next_stack_down;
			sys_class_q <= next_sys_class;
			sys_inv_q <= next_sys_inv;
			desc_bytes_q <= next_desc_bytes;
			priv_q <= next_priv;
		end
	end

	assign stack_grows_down_o = stack_down;
	assign sys_class_o = sys_class_q;
	assign sys_invalid_o = sys_inv_q;
	assign desc_bytes_o = desc_bytes_q;
	assign next_priv_o = priv_q;

	// checks on the fault, privilege, write-back and descriptor-size logic
	a_stack_nonwritable: assert property (@(posedge sys_clk_i) // R1
		disable iff (srst_i)
		load_req_i && load_target_i == SEG_STACK && !dl.wr_ok
		|-> general_protection_fault_o && !load_ok_o)
		else $error("stack load of non-writable segment not faulted");
	a_code_write_block: assert property (@(posedge sys_clk_i) // R7
		disable iff (srst_i)
		data_acc_req_i && data_acc_wr_i && acc_s_i &&
		acc_type_i[TYPE_CODE_BIT] |-> !acc_ok_o)
		else $error("write through code segment allowed");
	a_exec_only_read: assert property (@(posedge sys_clk_i) // R6
		disable iff (srst_i)
		data_acc_req_i && !data_acc_wr_i && acc_s_i &&
		acc_type_i[TYPE_CODE_BIT] && !acc_type_i[TYPE_WR_RD_BIT]
		|-> general_protection_fault_o)
		else $error("read of execute-only segment allowed");
	a_less_priv_xfer: assert property (@(posedge sys_clk_i) // R10
		disable iff (srst_i)
		xfer_req_i && !xfer_via_gate_i && desc_priv_i > cur_priv_i
		|-> !xfer_ok_o)
		else $error("transfer to less privileged code allowed");
	a_nonconf_xfer: assert property (@(posedge sys_clk_i) // R9
		disable iff (srst_i)
		xfer_req_i && !xfer_via_gate_i && desc_s_i &&
		!desc_type_i[TYPE_ED_CONF_BIT] && desc_priv_i != cur_priv_i
		|-> general_protection_fault_o)
		else $error("nonconforming cross-privilege transfer allowed");
	a_conf_keeps_priv: assert property (@(posedge sys_clk_i) // R8
		disable iff (srst_i)
		xfer_ok_o && !xfer_via_gate_i |=> next_priv_o == $past(cur_priv_i))
		else $error("conforming transfer changed privilege");
	a_data_priv: assert property (@(posedge sys_clk_i) // R11
		disable iff (srst_i)
		load_req_i && load_target_i >= SEG_DATA0 && desc_s_i &&
		!desc_type_i[TYPE_CODE_BIT] && cur_priv_i > desc_priv_i
		|-> !load_ok_o)
		else $error("data load from less privileged code allowed");
	a_acc_bit_set: assert property (@(posedge sys_clk_i) // R3
		disable iff (srst_i)
		wb_state == WB_IDLE && load_ok_o && desc_s_i && desc_mem_wr_ok_i &&
		!desc_type_i[TYPE_ACC_BIT]
		|=> acc_set_req_o && acc_set_type_o[TYPE_ACC_BIT])
		else $error("accessed bit not written after load");
	a_acc_never_clear: assert property (@(posedge sys_clk_i) // R4
		disable iff (srst_i)
		acc_set_req_o |-> acc_set_type_o[TYPE_ACC_BIT])
		else $error("accessed bit write would clear it");
	a_wide_sys: assert property (@(posedge sys_clk_i) // R18
		disable iff (srst_i)
		(load_req_i || xfer_req_i) && long_mode_i && !desc_s_i
		|=> desc_bytes_o == DESC_BYTES_WIDE)
		else $error("long mode system descriptor not wide");
	a_reserved_sys: assert property (@(posedge sys_clk_i) // R22
		disable iff (srst_i)
		(load_req_i || xfer_req_i) && !desc_s_i && !long_mode_i &&
		(desc_type_i == 4'h8 || desc_type_i == 4'ha || desc_type_i == 4'hd)
		|-> general_protection_fault_o ##1 sys_invalid_o)
		else $error("reserved system type not flagged");

	// checks on gate, system-load and stack decoding
	a_gate_type: assert property (@(posedge sys_clk_i) // R14
		disable iff (srst_i)
		xfer_req_i && xfer_via_gate_i && (desc_s_i ||
		desc_type_i == SYS_LDT || desc_type_i == SYS_UPPER_HALF)
		|-> general_protection_fault_o && !xfer_ok_o)
		else $error("transfer through a non-gate descriptor allowed");
	a_sys_load: assert property (@(posedge sys_clk_i) // R13
		disable iff (srst_i)
		load_req_i && !desc_s_i |-> general_protection_fault_o &&
		!load_ok_o)
		else $error("system descriptor load not faulted");
	a_stack_expand: assert property (@(posedge sys_clk_i) // R2
		disable iff (srst_i)
		load_ok_o && load_target_i == SEG_STACK &&
		desc_type_i[TYPE_ED_CONF_BIT] |=> stack_grows_down_o)
		else $error("expand-down stack not reported");

	c_stack_load: cover property (@(posedge sys_clk_i)
		load_ok_o && load_target_i == SEG_STACK && dl.expand_down);
	c_conf_xfer: cover property (@(posedge sys_clk_i)
		xfer_ok_o && dl.conforming && desc_priv_i < cur_priv_i);
	c_acc_wb: cover property (@(posedge sys_clk_i)
		acc_set_req_o ##[1:4] wb_state == WB_DONE);
	c_gate_xfer: cover property (@(posedge sys_clk_i)
		xfer_ok_o && xfer_via_gate_i && long_mode_i);
endmodule
`default_nettype wire

// ===== rtl/seg_check_pkg.sv
package seg_check_pkg;

	// type field bit positions inside the 4-bit type code
	localparam int TYPE_ACC_BIT = 0;
	localparam int TYPE_WR_RD_BIT = 1;
	localparam int TYPE_ED_CONF_BIT = 2;
	localparam int TYPE_CODE_BIT = 3;

	// privilege levels
	localparam logic [1:0] PRIV_MOST = 2'h0;
	localparam logic [1:0] PRIV_LEAST = 2'h3;

	// system type codes
	localparam logic [3:0] SYS_UPPER_HALF = 4'h0;
	localparam logic [3:0] SYS_TSS16_AVAIL = 4'h1;
	localparam logic [3:0] SYS_LDT = 4'h2;
	localparam logic [3:0] SYS_TSS16_BUSY = 4'h3;
	localparam logic [3:0] SYS_CALL16 = 4'h4;
	localparam logic [3:0] SYS_TASK_GATE = 4'h5;
	localparam logic [3:0] SYS_INT16 = 4'h6;
	localparam logic [3:0] SYS_TRAP16 = 4'h7;
	localparam logic [3:0] SYS_TSS_AVAIL = 4'h9;
	localparam logic [3:0] SYS_TSS_BUSY = 4'hb;
	localparam logic [3:0] SYS_CALL = 4'hc;
	localparam logic [3:0] SYS_INT = 4'he;
	localparam logic [3:0] SYS_TRAP = 4'hf;

	// descriptor sizes in bytes
	localparam logic [4:0] DESC_BYTES_LEGACY = 5'h08;
	localparam logic [4:0] DESC_BYTES_WIDE = 5'h10;

	// segment register targets of a load
	typedef enum logic [2:0] {
		SEG_CODE = 3'h0,
		SEG_STACK = 3'h1,
		SEG_DATA0 = 3'h2,
		SEG_DATA1 = 3'h3,
		SEG_DATA2 = 3'h4,
		SEG_DATA3 = 3'h5
	} seg_target_t;

	// decoded system descriptor class
	typedef enum logic [2:0] {
		SYS_NONE = 3'h0,
		SYS_CLS_LDT = 3'h1,
		SYS_CLS_TSS = 3'h2,
		SYS_CLS_CALL = 3'h3,
		SYS_CLS_INT = 3'h4,
		SYS_CLS_TRAP = 3'h5,
		SYS_CLS_TASK = 3'h6,
		SYS_CLS_UPPER = 3'h7
	} sys_class_t;

	// accessed-bit write-back sequence
	typedef enum logic [1:0] {
		WB_IDLE = 2'h0,
		WB_WRITE = 2'h1,
		WB_DONE = 2'h3
	} wb_state_t;

endpackage

// ===== rtl/type_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
// type decoder request and result between the checker and its decoder
interface type_dec_if;
	import seg_check_pkg::*;
	logic [3:0] type_code;
	logic s_flag;
	logic long_mode;
	logic is_code;
	logic is_data;
	logic is_system;
	logic acc;
	logic rd_ok;
	logic wr_ok;
	logic conforming;
	logic expand_down;
	sys_class_t sys_class;
	logic sys_wide;
	logic sys_invalid;
	logic [4:0] desc_bytes;
	modport client (output type_code, s_flag, long_mode,
		input is_code, is_data, is_system, acc, rd_ok, wr_ok, conforming,
		expand_down, sys_class, sys_wide, sys_invalid, desc_bytes);
	modport decoder (input type_code, s_flag, long_mode,
		output is_code, is_data, is_system, acc, rd_ok, wr_ok, conforming,
		expand_down, sys_class, sys_wide, sys_invalid, desc_bytes);
endinterface
`default_nettype wire

// ===== rtl/seg_type_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module seg_type_decoder (
	type_dec_if.decoder dec // type code in, decoded class out
);
	import seg_check_pkg::*;

	// system type lookup, per mode; reserved codes fall to sys_none
	function automatic sys_class_t sys_lookup(input logic [3:0] t,
		input logic lm);
		sys_class_t c;
		c = SYS_NONE;
		case (t)
			SYS_UPPER_HALF: c = lm ? SYS_CLS_UPPER : SYS_NONE; // R17
			SYS_LDT: c = SYS_CLS_LDT; // R15 R17
			SYS_TSS16_AVAIL, SYS_TSS16_BUSY: c = lm ? SYS_NONE : SYS_CLS_TSS;
			SYS_TSS_AVAIL, SYS_TSS_BUSY: c = SYS_CLS_TSS; // R15 R17
			SYS_CALL16: c = lm ? SYS_NONE : SYS_CLS_CALL; // R16
			SYS_TASK_GATE: c = lm ? SYS_NONE : SYS_CLS_TASK; // R16
			SYS_INT16: c = lm ? SYS_NONE : SYS_CLS_INT; // R16
			SYS_TRAP16: c = lm ? SYS_NONE : SYS_CLS_TRAP; // R16
			SYS_CALL: c = SYS_CLS_CALL; // R16 R17
			SYS_INT: c = SYS_CLS_INT; // R16 R17
			SYS_TRAP: c = SYS_CLS_TRAP; // R16 R17
			default: c = SYS_NONE;
		endcase
		return c;
	endfunction

	// application descriptor fields
	always_comb begin
		dec.is_system = !dec.s_flag; // R13
		dec.is_code = dec.s_flag && dec.type_code[TYPE_CODE_BIT]; // R19
		dec.is_data = dec.s_flag && !dec.type_code[TYPE_CODE_BIT]; // R19
		dec.acc = dec.s_flag && dec.type_code[TYPE_ACC_BIT]; // R5 R21
		dec.rd_ok = dec.is_data ||
			(dec.is_code && dec.type_code[TYPE_WR_RD_BIT]); // R6
		dec.wr_ok = dec.is_data && dec.type_code[TYPE_WR_RD_BIT]; // R7 R21
		dec.conforming = dec.is_code && dec.type_code[TYPE_ED_CONF_BIT]; // R5
		dec.expand_down = dec.is_data && dec.type_code[TYPE_ED_CONF_BIT];
	end

	// system descriptor class, width and validity
	always_comb begin
		dec.sys_class = dec.s_flag ? SYS_NONE :
			sys_lookup(dec.type_code, dec.long_mode); // R14
		dec.sys_invalid = !dec.s_flag && (dec.sys_class == SYS_NONE); // R22
		dec.sys_wide = !dec.s_flag && dec.long_mode; // R18
		dec.desc_bytes = dec.sys_wide ? DESC_BYTES_WIDE :
			DESC_BYTES_LEGACY; // R18
	end
endmodule
`default_nettype wire

// ===== verif/desc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// descriptor memory side: takes accessed-bit write-backs and answers late
module desc_mem_model (
	input wire logic sys_clk_i, // core clock
	input wire logic srst_i, // sync reset, active high
	input wire logic acc_set_req_i, // accessed-bit write request
	input wire logic [3:0] delay_i, // answer delay in cycles
	output logic acc_wr_done_o // one-cycle completion pulse
);
	logic [3:0] cnt;
	logic seen;

	// one pulse per request; a request level still high after the pulse
	// must not be taken as a second write
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cnt <= 4'h0;
			seen <= 1'b0;
			acc_wr_done_o <= 1'b0;
		end else if (acc_set_req_i && !seen) begin
			if (cnt == delay_i) begin
				acc_wr_done_o <= 1'b1;
				seen <= 1'b1;
			end else begin
				cnt <= cnt + 4'h1;
			end
		end else begin
			acc_wr_done_o <= 1'b0;
			if (!acc_set_req_i) begin
				seen <= 1'b0;
				cnt <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import seg_check_pkg::*;
	typedef struct packed {
		logic [1:0] k; // 0 load, 1 transfer, 2 access
		logic [1:0] cpl;
		logic [2:0] tgt;
		logic wr;
		logic [3:0] typ;
		logic [1:0] descriptor_privilege;
		logic ok;
	} row_t;
	logic sys_clk_i, srst_i, long_mode_i, load_req_i, xfer_req_i;
	logic xfer_via_gate_i, desc_s_i, desc_mem_wr_ok_i, data_acc_req_i;
	logic data_acc_wr_i, acc_s_i, acc_wr_done_i, grant, fault;
	logic general_protection_fault_o, load_ok_o, xfer_ok_o, acc_ok_o;
	logic acc_set_req_o, stack_grows_down_o, sys_invalid_o;
	logic [1:0] cur_priv_i, desc_priv_i, next_priv_o;
	logic [3:0] desc_type_i, acc_type_i, acc_set_type_o, delay;
	logic [4:0] desc_bytes_o;
	seg_target_t load_target_i;
	sys_class_t sys_class_o, c;
	int n_fail = 0;
	int checks_done = 0;
	// ordinary grants: kind, cpl, target, write, type, dpl, expected grant
	row_t rows [0:21] = '{
		'{2'h0, 2'h0, 3'h1, 1'b0, 4'h0, 2'h0, 1'b0},
		'{2'h0, 2'h0, 3'h1, 1'b0, 4'h2, 2'h0, 1'b1},
		'{2'h0, 2'h0, 3'h1, 1'b0, 4'ha, 2'h0, 1'b0},
		'{2'h0, 2'h0, 3'h2, 1'b0, 4'h8, 2'h0, 1'b0},
		'{2'h0, 2'h0, 3'h3, 1'b0, 4'ha, 2'h0, 1'b1},
		'{2'h0, 2'h3, 3'h4, 1'b0, 4'h2, 2'h0, 1'b0},
		'{2'h0, 2'h0, 3'h5, 1'b0, 4'h0, 2'h3, 1'b1},
		'{2'h0, 2'h3, 3'h2, 1'b0, 4'he, 2'h0, 1'b1},
		'{2'h1, 2'h0, 3'h0, 1'b0, 4'h8, 2'h0, 1'b1},
		'{2'h1, 2'h3, 3'h0, 1'b0, 4'h8, 2'h0, 1'b0},
		'{2'h1, 2'h3, 3'h0, 1'b0, 4'hc, 2'h0, 1'b1},
		'{2'h1, 2'h0, 3'h0, 1'b0, 4'hc, 2'h3, 1'b0},
		'{2'h1, 2'h0, 3'h0, 1'b0, 4'h8, 2'h3, 1'b0},
		'{2'h1, 2'h0, 3'h0, 1'b0, 4'h2, 2'h0, 1'b0},
		'{2'h1, 2'h2, 3'h0, 1'b0, 4'h9, 2'h2, 1'b1},
		'{2'h2, 2'h0, 3'h0, 1'b1, 4'h2, 2'h0, 1'b1},
		'{2'h2, 2'h0, 3'h0, 1'b1, 4'h0, 2'h0, 1'b0},
		'{2'h2, 2'h0, 3'h0, 1'b1, 4'ha, 2'h0, 1'b0},
		'{2'h2, 2'h0, 3'h0, 1'b1, 4'hf, 2'h0, 1'b0},
		'{2'h2, 2'h0, 3'h0, 1'b0, 4'h8, 2'h0, 1'b0},
		'{2'h2, 2'h0, 3'h0, 1'b0, 4'ha, 2'h0, 1'b1},
		'{2'h2, 2'h0, 3'h0, 1'b0, 4'h4, 2'h0, 1'b1}
	};

	segment_type_access_checker u_segment_type_access_checker (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .long_mode_i(long_mode_i),
		.cur_priv_i(cur_priv_i), .load_req_i(load_req_i),
		.load_target_i(load_target_i), .xfer_req_i(xfer_req_i),
		.xfer_via_gate_i(xfer_via_gate_i), .desc_type_i(desc_type_i),
		.desc_s_i(desc_s_i), .desc_priv_i(desc_priv_i),
		.desc_mem_wr_ok_i(desc_mem_wr_ok_i), .data_acc_req_i(data_acc_req_i),
		.data_acc_wr_i(data_acc_wr_i), .acc_type_i(acc_type_i),
		.acc_s_i(acc_s_i), .acc_wr_done_i(acc_wr_done_i),
		.general_protection_fault_o(general_protection_fault_o),
		.load_ok_o(load_ok_o), .xfer_ok_o(xfer_ok_o), .acc_ok_o(acc_ok_o),
		.next_priv_o(next_priv_o), .acc_set_req_o(acc_set_req_o),
		.acc_set_type_o(acc_set_type_o),
		.stack_grows_down_o(stack_grows_down_o), .sys_class_o(sys_class_o),
		.sys_invalid_o(sys_invalid_o), .desc_bytes_o(desc_bytes_o));
	desc_mem_model u_desc_mem_model (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.acc_set_req_i(acc_set_req_o), .delay_i(delay),
		.acc_wr_done_o(acc_wr_done_i));

	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	task automatic chk(input string name, input logic [4:0] exp,
		input logic [4:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			n_fail++;
		end
	endtask

	task automatic print_verdict();
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one request cycle; grant and fault are sampled once settled
	task automatic send(input logic [1:0] k, input logic lm,
		input logic [1:0] cpl, input logic [2:0] tgt, input logic g,
		input logic [3:0] typ, input logic s, input logic [1:0] descriptor_privilege);
		long_mode_i = lm;
		cur_priv_i = cpl;
		load_req_i = (k == 2'h0);
		xfer_req_i = (k == 2'h1);
		data_acc_req_i = (k == 2'h2);
		load_target_i = seg_target_t'(tgt);
		xfer_via_gate_i = g;
		data_acc_wr_i = g;
		desc_type_i = typ;
		acc_type_i = typ;
		desc_s_i = s;
		acc_s_i = s;
		desc_priv_i = descriptor_privilege;
		#1;
		grant = (k == 2'h0) ? load_ok_o : (k == 2'h1) ? xfer_ok_o : acc_ok_o;
		fault = general_protection_fault_o;
		@(posedge sys_clk_i);
		#1;
		load_req_i = 1'b0;
		xfer_req_i = 1'b0;
		data_acc_req_i = 1'b0;
		// idle edge, so the next request never meets this release
		@(posedge sys_clk_i);
		#1;
	endtask

	// bounded wait for the write-back to finish; a hang ends the run
	task automatic wait_idle();
		for (int i = 0; i < 20 && acc_set_req_o !== 1'b0; i++) begin
			@(posedge sys_clk_i);
			#1;
		end
		chk("acc_set_req_o", 5'h0, {4'h0, acc_set_req_o});
		if (acc_set_req_o !== 1'b0) print_verdict();
		@(posedge sys_clk_i);
		#1;
	endtask

	function automatic sys_class_t exp_cls(input logic [3:0] t, input logic m);
		case (t)
			SYS_UPPER_HALF: return m ? SYS_CLS_UPPER : SYS_NONE;
			SYS_LDT: return SYS_CLS_LDT;
			SYS_TSS_AVAIL, SYS_TSS_BUSY: return SYS_CLS_TSS;
			SYS_TSS16_AVAIL, SYS_TSS16_BUSY: return m ? SYS_NONE : SYS_CLS_TSS;
			SYS_CALL: return SYS_CLS_CALL;
			SYS_INT: return SYS_CLS_INT;
			SYS_TRAP: return SYS_CLS_TRAP;
			SYS_CALL16: return m ? SYS_NONE : SYS_CLS_CALL;
			SYS_INT16: return m ? SYS_NONE : SYS_CLS_INT;
			SYS_TRAP16: return m ? SYS_NONE : SYS_CLS_TRAP;
			SYS_TASK_GATE: return m ? SYS_NONE : SYS_CLS_TASK;
			default: return SYS_NONE;
		endcase
	endfunction

	initial begin
		{srst_i, long_mode_i, load_req_i, xfer_req_i, xfer_via_gate_i} = 5'h10;
		{desc_s_i, data_acc_req_i, data_acc_wr_i, acc_s_i} = 4'h0;
		{cur_priv_i, desc_priv_i, desc_type_i, acc_type_i} = 12'h0;
		load_target_i = SEG_CODE;
		desc_mem_wr_ok_i = 1'b1;
		delay = 4'h0;
		repeat (10) @(posedge sys_clk_i);
		#1;
		// reset values of the status outputs
		chk("desc_bytes_o", 5'h08, desc_bytes_o);
		chk("sys_class_o", 5'h0, {2'h0, sys_class_o});
		chk("acc_set_req_o", 5'h0, {4'h0, acc_set_req_o});
		chk("next_priv_o", 5'h0, {3'h0, next_priv_o});
		srst_i = 1'b0;
		foreach (rows[i]) begin
			send(rows[i].k, 1'b0, rows[i].cpl, rows[i].tgt, rows[i].wr,
				rows[i].typ, 1'b1, rows[i].descriptor_privilege);
			chk("grant", {4'h0, rows[i].ok}, {4'h0, grant});
			chk("fault", {4'h0, !rows[i].ok}, {4'h0, fault});
		end
		wait_idle();
		// every system type through a gate, both modes
		for (int m = 0; m < 2; m++) begin
			for (int t = 0; t < 16; t++) begin
				send(2'h1, m[0], 2'h0, 3'h0, 1'b1, t[3:0], 1'b0, 2'h0);
				c = exp_cls(t[3:0], m[0]);
				chk("gate_ok", {4'h0, c inside {SYS_CLS_CALL, SYS_CLS_INT,
					SYS_CLS_TRAP, SYS_CLS_TASK}}, {4'h0, grant});
				chk("sys_invalid_o", {4'h0, c == SYS_NONE}, {4'h0, sys_invalid_o});
				if (c != SYS_NONE) begin
					chk("sys_class_o", {2'h0, c}, {2'h0, sys_class_o});
				end
				chk("desc_bytes_o", m ? 5'h10 : 5'h08, desc_bytes_o);
			end
		end
		send(2'h0, 1'b1, 2'h0, 3'h2, 1'b0, 4'h2, 1'b1, 2'h0);
		chk("desc_bytes_o", 5'h08, desc_bytes_o);
		send(2'h0, 1'b0, 2'h0, 3'h2, 1'b0, 4'h2, 1'b0, 2'h0);
		chk("load_ok_o", 5'h0, {4'h0, grant});
		send(2'h1, 1'b0, 2'h3, 3'h0, 1'b0, 4'hc, 1'b1, 2'h0);
		chk("next_priv_o", 5'h3, {3'h0, next_priv_o});
		// code register load takes no type check
		send(2'h0, 1'b0, 2'h3, 3'h0, 1'b0, 4'h8, 1'b1, 2'h0);
		chk("load_ok_o", 5'h1, {4'h0, grant});
		// expand-down stack, then expand-up
		send(2'h0, 1'b0, 2'h0, 3'h1, 1'b0, 4'h6, 1'b1, 2'h0);
		chk("stack_grows_down_o", 5'h1, {4'h0, stack_grows_down_o});
		send(2'h0, 1'b0, 2'h0, 3'h1, 1'b0, 4'h2, 1'b1, 2'h0);
		chk("stack_grows_down_o", 5'h0, {4'h0, stack_grows_down_o});
		wait_idle();
		// slow memory: request must stand until the write completes
		delay = 4'h5;
		send(2'h0, 1'b0, 2'h0, 3'h3, 1'b0, 4'h2, 1'b1, 2'h0);
		chk("acc_set_req_o", 5'h1, {4'h0, acc_set_req_o});
		chk("acc_set_type_o", 5'h3, {1'h0, acc_set_type_o});
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk("acc_set_req_o", 5'h1, {4'h0, acc_set_req_o});
		wait_idle();
		// accessed bit preset: no write-back
		send(2'h0, 1'b0, 2'h0, 3'h4, 1'b0, 4'h3, 1'b1, 2'h0);
		chk("acc_set_req_o", 5'h0, {4'h0, acc_set_req_o});
		// read-only descriptor memory: no write-back
		desc_mem_wr_ok_i = 1'b0;
		send(2'h0, 1'b0, 2'h0, 3'h5, 1'b0, 4'h2, 1'b1, 2'h0);
		chk("acc_set_req_o", 5'h0, {4'h0, acc_set_req_o});
		// reset in mid write-back
		desc_mem_wr_ok_i = 1'b1;
		send(2'h0, 1'b0, 2'h0, 3'h2, 1'b0, 4'h0, 1'b1, 2'h0);
		srst_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		srst_i = 1'b0;
		chk("acc_set_req_o", 5'h0, {4'h0, acc_set_req_o});
		chk("desc_bytes_o", 5'h08, desc_bytes_o);
		chk("acc_set_type_o", 5'h0, {1'h0, acc_set_type_o});
		print_verdict();
	end
endmodule
`default_nettype wire
